// ==== design/evt_ctrl_cfg.svh ====
// Purpose: offsets, reset values and field positions of the event controller
// Assumes: register port addressed by word index
// Notes: definitions only
`ifndef EVT_CTRL_CFG_SVH
`define EVT_CTRL_CFG_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define CORE_LATCH_IDX 4'h0
`define CORE_MASK_IDX 4'h1
`define CORE_PEND_IDX 4'h2
`define SYS_MASK_IDX 4'h3
`define SYS_STATUS_IDX 4'h4
`define SYS_WAKE_IDX 4'h5
`define SYS_ASSIGN0_IDX 4'h6
`define SYS_ASSIGN3_IDX 4'h9

// ****************************************************************
// reset values and fixed fields
// ****************************************************************
`define CORE_MASK_RST 16'h0000
`define SYS_MASK_RST 32'h0000_0000
`define SYS_WAKE_RST 32'h0000_0000
`define SYS_ASSIGN0_RST 32'h1000_0000
`define SYS_ASSIGN1_RST 32'h3332_2221
`define SYS_ASSIGN2_RST 32'h6665_5444
`define SYS_ASSIGN3_RST 32'h0000_0000
// events 0..3 cannot be masked, event 4 is reserved
`define CORE_UNMASKABLE 16'h000f
`define CORE_RESERVED 16'h0010
// first general-purpose event number
`define GP_FIRST 4'h7
`define GP_VALID 16'hff80

`endif

// ==== design/evt_ctrl_pkg.sv ====
// Purpose: shared types and decode function of the event controller
// Assumes: sixteen core events, nine general-purpose inputs
// Notes: constants live in evt_ctrl_cfg.svh
package evt_ctrl_pkg;

	typedef logic [3:0] event_id_t;
	typedef logic [15:0] event_vec_t;
	typedef logic [8:0] gp_vec_t;

	// one-hot decode of an event number
	function automatic event_vec_t onehot16(input event_id_t id);
		event_vec_t v;
		v = 16'h0000;
		v[id] = 1'b1;
		return v;
	endfunction : onehot16

endpackage : evt_ctrl_pkg

// ==== design/system_stage.sv ====
// Purpose: peripheral mask, status, wakeup and routing to core inputs
// Assumes: peripheral requests are levels from another clock domain
// Notes: a routed line stays high until its core event is acknowledged
`timescale 1ns/1ps
`include "evt_ctrl_cfg.svh"

module system_stage (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// register write path
	input wire logic wr_hit,
	input wire logic [3:0] wr_addr,
	input wire logic [31:0] wr_data,
	// peripherals and power
	input wire logic [31:0] periph_irq,
	input wire logic core_idle,
	// core side
	input wire evt_ctrl_pkg::gp_vec_t gp_pending,
	output logic [8:0] gp_req,
	output logic wake_core,
	// readback
	output logic [31:0] src_mask,
	output logic [31:0] src_status,
	output logic [31:0] src_wake,
	output logic [127:0] src_assign
);

	logic [31:0] irq_s1_reg;
	logic [31:0] status_reg, status_d_reg;
	logic [31:0] mask_reg, mask_next, wake_reg, wake_next;
	logic [127:0] assign_reg, assign_next;
	logic [31:0] fresh_reg, fresh_next;
	logic [8:0] pend_d_reg;
	logic wake_core_reg, wake_core_next;
	logic [15:0] gp_ack;
	logic [31:0] src_edge;

	// ****************************************************************
	// synchroniser, status and pending edge history
	// ****************************************************************
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_s1_reg <= 32'h0000_0000;
			status_reg <= 32'h0000_0000;
			status_d_reg <= 32'h0000_0000;
			pend_d_reg <= 9'h000;
		end else begin
			irq_s1_reg <= periph_irq;
			status_reg <= irq_s1_reg;
			status_d_reg <= status_reg;
			pend_d_reg <= gp_pending;
		end
	end

	// ****************************************************************
	// registers and routing
	// ****************************************************************
	// unrouted codes count as acknowledged so no stale flag waits there
	assign gp_ack = {7'h7f, gp_pending & ~pend_d_reg};
	assign src_edge = status_reg & ~status_d_reg & mask_reg;

	always_comb begin
		mask_next = mask_reg;
		wake_next = wake_reg;
		assign_next = assign_reg;
		if (wr_hit && wr_addr == `SYS_MASK_IDX) begin
			mask_next = wr_data;
		end else if (wr_hit && wr_addr == `SYS_WAKE_IDX) begin
			wake_next = wr_data;
		end else if (wr_hit && wr_addr >= `SYS_ASSIGN0_IDX &&
		    wr_addr <= `SYS_ASSIGN3_IDX) begin
			assign_next[(wr_addr - `SYS_ASSIGN0_IDX) * 32 +: 32] = wr_data;
		end
		// pending rise acknowledges, new edge wins
		for (int s = 0; s < 32; s++) begin
			if (src_edge[s]) begin
				fresh_next[s] = 1'b1;
			end else if (gp_ack[assign_reg[s*4 +: 4]]) begin
				fresh_next[s] = 1'b0;
			end else begin
				fresh_next[s] = fresh_reg[s];
			end
		end
		gp_req = 9'h000;
		for (int s = 0; s < 32; s++) begin
			if (assign_reg[s*4 +: 4] < 4'h9) begin
				gp_req[assign_reg[s*4 +: 4]] |= fresh_reg[s];
			end
		end
		wake_core_next = core_idle && |(status_reg & wake_reg);
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mask_reg <= `SYS_MASK_RST;
			wake_reg <= `SYS_WAKE_RST;
			assign_reg <= {`SYS_ASSIGN3_RST, `SYS_ASSIGN2_RST,
			    `SYS_ASSIGN1_RST, `SYS_ASSIGN0_RST};
			fresh_reg <= 32'h0000_0000;
			wake_core_reg <= 1'b0;
		end else begin
			mask_reg <= mask_next;
			wake_reg <= wake_next;
			assign_reg <= assign_next;
			fresh_reg <= fresh_next;
			wake_core_reg <= wake_core_next;
		end
	end

	assign wake_core = wake_core_reg;
	assign src_mask = mask_reg;
	assign src_status = status_reg;
	assign src_wake = wake_reg;
	assign src_assign = assign_reg;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_status_follow: assert property (
		status_reg == $past(periph_irq, 2))
		else $error("status does not follow request");
	a_mask_blocks: assert property (
		(!mask_reg[0] && !fresh_reg[0]) |=> !fresh_reg[0])
		else $error("masked source was forwarded");
	a_wake_idle: assert property (
		(core_idle && |(status_reg & wake_reg)) |=> wake_core)
		else $error("idle core not woken");
	c_wake: cover property (wake_core);

endmodule : system_stage

// ==== design/two_stage_event_controller.sv ====
// Purpose: core stage with latch, mask, pending tracking, plus system stage
// Assumes: supervisor register port; pipeline takes at most one event every other cycle
// Notes: register reads answer one cycle after the access
`timescale 1ns/1ps
`include "evt_ctrl_cfg.svh"

module two_stage_event_controller (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// register port
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic supervisor,
	output logic [31:0] reg_rdata,
	// dedicated event pins, priorities 0..6
	input wire logic [6:0] fixed_event_in,
	// peripheral requests
	input wire logic [31:0] periph_irq,
	// pipeline hand-off
	output logic event_req,
	output evt_ctrl_pkg::event_id_t event_id,
	input wire logic event_take,
	input wire logic event_return,
	input wire evt_ctrl_pkg::event_id_t return_id,
	// global enable instructions
	input wire logic gie_enable_instr,
	input wire logic gie_disable_instr,
	output logic global_irq_enabled,
	// power
	input wire logic core_idle,
	output logic wake_core
);

	logic [6:0] fix_s1_reg, fix_s2_reg;
	evt_ctrl_pkg::event_vec_t ev_d1_reg, ev_d2_reg, ev_edge;
	evt_ctrl_pkg::event_vec_t latch_reg, latch_next;
	evt_ctrl_pkg::event_vec_t mask_reg, mask_next, mask_eff;
	evt_ctrl_pkg::event_vec_t pend_reg, pend_next;
	logic gie_reg, gie_next;
	logic req_reg, req_next;
	evt_ctrl_pkg::event_id_t id_reg, id_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [8:0] gp_req;
	logic [31:0] src_mask, src_status, src_wake;
	logic [127:0] src_assign;
	logic sw_wr, take_fire;
	evt_ctrl_pkg::event_vec_t cand;
	evt_ctrl_pkg::event_id_t cand_id, top_pend;
	logic cand_any, pend_any, cand_ok;

	assign sw_wr = reg_sel && reg_wr && supervisor;
	assign take_fire = req_reg && event_take;

	// ****************************************************************
	// system stage
	// ****************************************************************
	// routed lines come back on our clock, so they skip the pin flops
	system_stage u_system_stage (
		.core_clk(core_clk),
		.reset(reset),
		.wr_hit(sw_wr),
		.wr_addr(reg_addr),
		.wr_data(reg_wdata),
		.periph_irq(periph_irq),
		.core_idle(core_idle),
		.gp_pending(pend_reg[15:7]),
		.gp_req(gp_req),
		.wake_core(wake_core),
		.src_mask(src_mask),
		.src_status(src_status),
		.src_wake(src_wake),
		.src_assign(src_assign)
	);

	// ****************************************************************
	// input capture and edge detection
	// ****************************************************************
	// dedicated pins cross two flops; routed lines share our clock
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fix_s1_reg <= 7'h00;
			fix_s2_reg <= 7'h00;
			ev_d1_reg <= 16'h0000;
			ev_d2_reg <= 16'h0000;
		end else begin
			fix_s1_reg <= fixed_event_in;
			fix_s2_reg <= fix_s1_reg;
			// nine general inputs above the dedicated ones
			ev_d1_reg <= {gp_req, fix_s2_reg};
			ev_d2_reg <= ev_d1_reg;
		end
	end

	// the delayed copy keeps a held line from latching twice
	// one-cycle rising edge detect
	assign ev_edge = ev_d1_reg & ~ev_d2_reg & ~`CORE_RESERVED;

	// ****************************************************************
	// priority selection
	// ****************************************************************
	// global disable only gates the general-purpose events
	assign mask_eff = (mask_reg | `CORE_UNMASKABLE) &
	    (gie_reg ? 16'hffff : ~`GP_VALID) & ~`CORE_RESERVED;

	// lowest number wins, must outrank active events
	always_comb begin
		cand = latch_reg & mask_eff;
		cand_any = |cand;
		pend_any = |pend_reg;
		cand_id = 4'h0;
		top_pend = 4'h0;
		// scanning downward leaves the lowest index, the top priority
		for (int i = 15; i >= 0; i--) begin
			if (cand[i]) begin
				cand_id = 4'(i);
			end
			if (pend_reg[i]) begin
				top_pend = 4'(i);
			end
		end
		// an equal rank waits: one level never nests on itself
		cand_ok = cand_any && (!pend_any || cand_id < top_pend);
	end

	// ****************************************************************
	// latch, pending, mask, global enable and hand-off
	// ****************************************************************
	always_comb begin
		latch_next = latch_reg;
		mask_next = mask_reg;
		pend_next = pend_reg;
		gie_next = gie_reg;
		if (sw_wr && reg_addr == `CORE_MASK_IDX) begin
			mask_next = reg_wdata[15:0] & ~`CORE_RESERVED;
		end
		// only where the stored mask bit is clear, events 0..3 included
		if (sw_wr && reg_addr == `CORE_LATCH_IDX) begin
			latch_next = latch_next & ~(reg_wdata[15:0] & ~mask_reg);
		end
		if (take_fire) begin
			latch_next = latch_next & ~evt_ctrl_pkg::onehot16(id_reg);
		end
		// capture comes last so a fresh edge survives a cancel or a take
		// a new edge is latched again, set wins
		latch_next = latch_next | ev_edge;
		// return ends nesting at that level
		if (event_return) begin
			pend_next = pend_next & ~evt_ctrl_pkg::onehot16(return_id);
		end
		if (take_fire) begin
			pend_next = pend_next | evt_ctrl_pkg::onehot16(id_reg);
		end
		// disable wins when both arrive together
		if (gie_disable_instr) begin
			gie_next = 1'b0;
		end else if (gie_enable_instr) begin
			gie_next = 1'b1;
		end
		// accepted request withdraws until state settles
		// registered request, pending three cycles at the soonest
		req_next = cand_ok && !take_fire;
		id_next = cand_id;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			latch_reg <= 16'h0000;
			mask_reg <= `CORE_MASK_RST;
			pend_reg <= 16'h0000;
			gie_reg <= 1'b0;
			req_reg <= 1'b0;
			id_reg <= 4'h0;
		end else begin
			latch_reg <= latch_next;
			mask_reg <= mask_next;
			pend_reg <= pend_next;
			gie_reg <= gie_next;
			req_reg <= req_next;
			id_reg <= id_next;
		end
	end

	// ****************************************************************
	// register readback
	// ****************************************************************
	// 32-bit registers, unused high bits read zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (reg_sel && !reg_wr && supervisor) begin
			if (reg_addr == `CORE_LATCH_IDX) begin
				rdata_next = {16'h0000, latch_reg};
			end else if (reg_addr == `CORE_MASK_IDX) begin
				rdata_next = {16'h0000, mask_reg | `CORE_UNMASKABLE};
			end else if (reg_addr == `CORE_PEND_IDX) begin
				rdata_next = {16'h0000, pend_reg};
			end else if (reg_addr == `SYS_MASK_IDX) begin
				rdata_next = src_mask;
			end else if (reg_addr == `SYS_STATUS_IDX) begin
				rdata_next = src_status;
			end else if (reg_addr == `SYS_WAKE_IDX) begin
				rdata_next = src_wake;
			end else if (reg_addr >= `SYS_ASSIGN0_IDX &&
			    reg_addr <= `SYS_ASSIGN3_IDX) begin
				rdata_next = src_assign[(reg_addr - `SYS_ASSIGN0_IDX) * 32 +: 32];
			end
		end
	end

	// registered reads keep the address decode off the data pins
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign event_req = req_reg;
	assign event_id = id_reg;
	assign global_irq_enabled = gie_reg;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_edge_sets_latch: assert property (
		$rose(gp_req[0]) |-> ##2 latch_reg[7])
		else $error("edge on first general input not latched");
	a_take_sets_pend: assert property (
		(take_fire && !event_return) |=> pend_reg[$past(id_reg)])
		else $error("accepted event not pending");
	a_take_clr_latch: assert property (
		(take_fire && !ev_edge[id_reg]) |=> !latch_reg[$past(id_reg)])
		else $error("latch not cleared on acceptance");
	a_min_latency: assert property (
		($rose(gp_req[0]) && !latch_reg[7] && !pend_reg[7] && !req_reg)
		|-> !pend_reg[7] [*3])
		else $error("pending rose too early");
	a_req_unmasked: assert property (
		event_req |-> $past(latch_reg[cand_id] && mask_eff[cand_id]))
		else $error("request for masked or unlatched event");
	a_pend_sw_ro: assert property (
		(reg_sel && reg_wr && reg_addr == `CORE_PEND_IDX &&
		    !take_fire && !event_return) |=> $stable(pend_reg))
		else $error("software changed pending");
	a_soft_cancel: assert property (
		(sw_wr && reg_addr == `CORE_LATCH_IDX && reg_wdata[5] &&
		    !mask_reg[5] && !ev_edge[5]) |=> !latch_reg[5])
		else $error("latch cancel ignored");
	a_mask_write: assert property (
		(sw_wr && reg_addr == `CORE_MASK_IDX) |=>
		    mask_reg[15:5] == $past(reg_wdata[15:5]))
		else $error("mask write lost");
	a_gie_gates: assert property (
		!gie_reg |=> !(event_req && event_id >= `GP_FIRST))
		else $error("general event requested while disabled");
	a_outrank: assert property (
		(event_req && $past(pend_any)) |-> event_id < $past(top_pend))
		else $error("request does not outrank active event");

	// hand-off and nesting checks
	a_req_drops: assert property (
		take_fire |=> !event_req)
		else $error("request stood after acceptance");
	a_return_clears: assert property (
		(event_return && !(take_fire && id_reg == return_id)) |=>
		    !pend_reg[$past(return_id)])
		else $error("returned event still pending");
	a_requeue_edge: assert property (
		(ev_edge[7] && pend_reg[7]) |=> latch_reg[7])
		else $error("edge during active event lost");
	a_reserved_idle: assert property (
		!latch_reg[4] && !pend_reg[4])
		else $error("reserved event became active");
	a_unmasked_served: assert property (
		(cand_ok && !take_fire) |=>
		    (event_req && event_id == $past(cand_id)))
		else $error("unmasked event not requested");
	a_idle_no_req: assert property (
		!cand_any |=> !event_req)
		else $error("request without a candidate");

	// register port and global disable checks
	a_cancel_refused: assert property (
		(sw_wr && reg_addr == `CORE_LATCH_IDX && mask_reg[7] &&
		    latch_reg[7] && !take_fire) |=> latch_reg[7])
		else $error("cancel of unmasked event taken");
	a_user_read_zero: assert property (
		(reg_sel && !reg_wr && !supervisor) |=>
		    reg_rdata == 32'h0000_0000)
		else $error("user-mode read returned data");
	a_rdata_idle: assert property (
		!(reg_sel && !reg_wr) |=> reg_rdata == 32'h0000_0000)
		else $error("read data stood without a read");
	a_gie_disable: assert property (
		gie_disable_instr |=> !global_irq_enabled)
		else $error("global disable ignored");

	// ****************************************************************
	// cover points
	// ****************************************************************
	c_take: cover property (take_fire);
	c_nested: cover property (take_fire && pend_any);
	c_cancel: cover property (sw_wr && reg_addr == `CORE_LATCH_IDX);
	c_outranked: cover property (cand_any && !cand_ok);

endmodule : two_stage_event_controller

// ==== tb/pipe_model.sv ====
// Purpose: pipeline side that takes events and later returns them
// Assumes: one take at a time, handlers return innermost first
// Notes: run_len of 8'hff keeps every handler open
`timescale 1ns/1ps
module pipe_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// requests from the controller
	input wire logic event_req,
	input wire evt_ctrl_pkg::event_id_t event_id,
	// pacing set by the bench
	input wire logic [3:0] take_wait,
	input wire logic [7:0] run_len,
	// answers to the controller
	output logic event_take,
	output logic event_return,
	output evt_ctrl_pkg::event_id_t return_id
);
	evt_ctrl_pkg::event_id_t stk[$];
	int wcnt;
	int rcnt;

	// take after a wait, return nested handlers in reverse order
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			event_take <= 1'b0;
			event_return <= 1'b0;
			return_id <= 4'h0;
			wcnt <= 0;
			rcnt <= 0;
			stk.delete();
		end else begin
			event_take <= 1'b0;
			event_return <= 1'b0;
			// idle id wanders so a stale value is never trusted
			return_id <= ~return_id;
			if (event_req && event_take) begin
				stk.push_back(event_id);
				rcnt <= 0;
				wcnt <= 0;
			end else if (event_req) begin
				if (wcnt >= take_wait) begin
					event_take <= 1'b1;
				end else begin
					wcnt <= wcnt + 1;
				end
			end else if (stk.size() > 0 && run_len != 8'hff) begin
				if (rcnt >= run_len) begin
					event_return <= 1'b1;
					return_id <= stk[$];
					stk.pop_back();
					rcnt <= 0;
				end else begin
					rcnt <= rcnt + 1;
				end
			end
		end
	end
endmodule : pipe_model

// ==== tb/two_stage_event_controller_bench.sv ====
// Purpose: self-checking bench of the two-stage event controller
// Assumes: supervisor register port, pipeline model on the far side
// Notes: register table first, then routing, nesting and masking
`timescale 1ns/1ps
`include "evt_ctrl_cfg.svh"
module two_stage_event_controller_bench;
	logic core_clk, reset, reg_sel, reg_wr, supervisor;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, periph_irq, v;
	logic [6:0] fixed_event_in;
	logic event_req, event_take, event_return, gie_en, gie_dis;
	logic global_irq_enabled, core_idle, wake_core;
	evt_ctrl_pkg::event_id_t event_id, return_id;
	logic [3:0] take_wait;
	logic [7:0] run_len;
	int error_cnt, tests_run, n;
	typedef struct {
		logic do_wr;
		logic [3:0] addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} row_s;
	row_s rows[19];

	two_stage_event_controller DUT (.core_clk(core_clk), .reset(reset),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .supervisor(supervisor),
		.reg_rdata(reg_rdata), .fixed_event_in(fixed_event_in),
		.periph_irq(periph_irq), .event_req(event_req),
		.event_id(event_id), .event_take(event_take),
		.event_return(event_return), .return_id(return_id),
		.gie_enable_instr(gie_en), .gie_disable_instr(gie_dis),
		.global_irq_enabled(global_irq_enabled), .core_idle(core_idle),
		.wake_core(wake_core));
	pipe_model pipe (.core_clk(core_clk), .reset(reset),
		.event_req(event_req), .event_id(event_id),
		.take_wait(take_wait), .run_len(run_len),
		.event_take(event_take), .event_return(event_return),
		.return_id(return_id));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : tick

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_sel <= 1'b1;
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_sel <= 1'b0;
		reg_wr <= 1'b0;
	endtask : wr

	// read data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_sel <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_sel <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic gie(input logic en);
		@(posedge core_clk);
		gie_en <= en;
		gie_dis <= !en;
		@(posedge core_clk);
		gie_en <= 1'b0;
		gie_dis <= 1'b0;
		#1;
	endtask : gie

	// bounded wait, a hang ends the run through the report
	task automatic wait_req(output int c);
		c = 0;
		while (event_req !== 1'b1) begin
			tick(1);
			c++;
			if (c > 200) begin
				chk("event_req wait", 32'h1, 32'h0);
				stop_test();
			end
		end
	endtask : wait_req

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{reset, supervisor} = 2'b11;
		{reg_sel, reg_wr, gie_en, gie_dis, core_idle} = 5'h00;
		{reg_addr, take_wait} = 8'h00;
		{reg_wdata, periph_irq} = 64'h0;
		fixed_event_in = 7'h00;
		run_len = 8'hff;
		{error_cnt, tests_run} = 0;
		rows = '{
			'{1'b0, 4'h0, 32'h0, 32'h0},
			'{1'b0, 4'h1, 32'h0, 32'h0000_000f},
			'{1'b0, 4'h2, 32'h0, 32'h0},
			'{1'b0, 4'h3, 32'h0, 32'h0},
			'{1'b0, 4'h4, 32'h0, 32'h0},
			'{1'b0, 4'h5, 32'h0, 32'h0},
			'{1'b0, 4'h6, 32'h0, `SYS_ASSIGN0_RST},
			'{1'b0, 4'h7, 32'h0, `SYS_ASSIGN1_RST},
			'{1'b0, 4'h8, 32'h0, `SYS_ASSIGN2_RST},
			'{1'b0, 4'h9, 32'h0, `SYS_ASSIGN3_RST},
			'{1'b0, 4'ha, 32'h0, 32'h0},
			'{1'b1, 4'h1, 32'hffff_ffff, 32'h0000_ffef},
			'{1'b1, 4'h1, 32'h0, 32'h0000_000f},
			'{1'b1, 4'h2, 32'hffff_ffff, 32'h0},
			'{1'b1, 4'h3, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
			'{1'b1, 4'h4, 32'hffff_ffff, 32'h0},
			'{1'b1, 4'h5, 32'h5a5a_a5a5, 32'h5a5a_a5a5},
			'{1'b1, 4'h3, 32'h0, 32'h0},
			'{1'b1, 4'h5, 32'h0, 32'h0}
		};
		tick(6);
		reset <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].do_wr) begin
				wr(rows[i].addr, rows[i].wdata);
			end
			rd(rows[i].addr, v);
			chk($sformatf("reg %0h", rows[i].addr), rows[i].exp, v);
		end
		$display("test register table done");
		supervisor <= 1'b0;
		wr(4'h1, 32'h0000_ff80);
		rd(4'h1, v);
		chk("user read", 32'h0, v);
		supervisor <= 1'b1;
		rd(4'h1, v);
		chk("mask kept", 32'h0000_000f, v);
		$display("test supervisor done");
		wr(4'h1, 32'h0000_0080);
		gie(1'b1);
		chk("global on", 32'h1, {31'h0, global_irq_enabled});
		wr(4'h3, 32'h0000_0001);
		take_wait <= 4'h2;
		periph_irq <= 32'h1;
		wait_req(n);
		chk("latency ok", 32'h1, {31'h0, n >= 3});
		chk("id", 32'h7, {28'h0, event_id});
		tick(4);
		rd(4'h2, v);
		chk("pending", 32'h0000_0080, v);
		rd(4'h0, v);
		chk("latch", 32'h0, v);
		rd(4'h4, v);
		chk("status", 32'h1, v);
		$display("test routing done");
		periph_irq <= 32'h0;
		tick(4);
		periph_irq <= 32'h1;
		tick(10);
		rd(4'h0, v);
		chk("requeue", 32'h0000_0080, v);
		chk("no req", 32'h0, {31'h0, event_req});
		fixed_event_in <= 7'h04;
		wait_req(n);
		chk("nest id", 32'h2, {28'h0, event_id});
		tick(4);
		rd(4'h2, v);
		chk("nested", 32'h0000_0084, v);
		run_len <= 8'h02;
		tick(40);
		rd(4'h2, v);
		chk("unwound", 32'h0, v);
		rd(4'h0, v);
		chk("latch empty", 32'h0, v);
		fixed_event_in <= 7'h00;
		$display("test nesting done");
		gie(1'b0);
		chk("global off", 32'h0, {31'h0, global_irq_enabled});
		periph_irq <= 32'h0;
		tick(4);
		periph_irq <= 32'h1;
		tick(10);
		chk("held", 32'h0, {31'h0, event_req});
		wr(4'h0, 32'h0000_0080);
		rd(4'h0, v);
		chk("latch kept", 32'h0000_0080, v);
		gie(1'b1);
		wait_req(n);
		chk("released", 32'h7, {28'h0, event_id});
		tick(20);
		$display("test global enable done");
		wr(4'h1, 32'h0);
		fixed_event_in <= 7'h20;
		tick(10);
		rd(4'h0, v);
		chk("pin latch", 32'h0000_0020, v);
		chk("masked", 32'h0, {31'h0, event_req});
		wr(4'h0, 32'h0000_0020);
		rd(4'h0, v);
		chk("cancel", 32'h0, v);
		fixed_event_in <= 7'h00;
		tick(4);
		fixed_event_in <= 7'h20;
		tick(10);
		wr(4'h1, 32'h0000_0020);
		wait_req(n);
		chk("unmasked", 32'h5, {28'h0, event_id});
		tick(20);
		fixed_event_in <= 7'h00;
		$display("test core mask done");
		wr(4'h6, 32'h1000_0001);
		wr(4'h1, 32'h0000_0100);
		periph_irq <= 32'h0;
		tick(4);
		periph_irq <= 32'h1;
		wait_req(n);
		chk("rerouted", 32'h8, {28'h0, event_id});
		tick(20);
		$display("test assignment done");
		periph_irq <= 32'h9;
		core_idle <= 1'b1;
		wr(4'h5, 32'h0000_0008);
		tick(4);
		chk("wake", 32'h1, {31'h0, wake_core});
		rd(4'h4, v);
		chk("status pair", 32'h0000_0009, v);
		wr(4'h5, 32'h0);
		tick(4);
		chk("no wake", 32'h0, {31'h0, wake_core});
		$display("test wakeup done");
		// both instructions in one cycle, disable wins
		@(posedge core_clk);
		gie_en <= 1'b1;
		gie_dis <= 1'b1;
		@(posedge core_clk);
		gie_en <= 1'b0;
		gie_dis <= 1'b0;
		#1;
		chk("both gie", 32'h0, {31'h0, global_irq_enabled});
		// mid-run reset, quiet inputs so status history starts clean
		periph_irq <= 32'h0;
		core_idle <= 1'b0;
		tick(4);
		reset <= 1'b1;
		tick(2);
		chk("reset outputs", 32'h0,
			{29'h0, event_req, wake_core, global_irq_enabled});
		reset <= 1'b0;
		rd(4'h1, v);
		chk("reset mask", 32'h0000_000f, v);
		rd(4'h6, v);
		chk("reset map", `SYS_ASSIGN0_RST, v);
		$display("test reset done");
		stop_test();
	end
endmodule : two_stage_event_controller_bench
